// [rtl/sfc_pkg.sv]
/*
  Constants, mode type and command field layout for the SPI slave frame
  checker. Assumes a 16-bit LSB-first frame, low byte address plus access
  bit, high byte data.

  // Operation
  // RULE1: Serial port works only in Init, Normal and Stop modes.
  // RULE2: Full-duplex 16-bit frames; no pass-through of received bits.
  // RULE3: Frame opens on chip select low; on rise decode and float output.
  // RULE4: Sample input on falling clock; advance output after rising clock.
  // RULE5: Bad or prohibited command drops write and sets sticky fail flag.
  // RULE6: Stop to Sleep request flags fail and goes to Restart.
  // RULE7: Stop or Sleep request from Init flags fail and goes Normal.
  // RULE8: Watchdog byte with odd parity flags fail and is ignored.
  // RULE9: In Stop only watchdog, Normal, soft reset, status clear pass.
  // RULE10: Stop request with bus and second wake controls zero is fine.
  // RULE11: Stop entry with pending wake status pulses interrupt, no fail.
  // RULE12: Stop to Normal write applies only the mode change.
  // RULE13: Sleep without wake source flags fail, Restart, rest executes.
  // RULE14: Sleep with only a stopped timer wakes at once to Restart.
  // RULE15: Measurement versus fail output or pin settings conflict flags fail.
  // RULE16: Timer on-time not shorter than its period flags fail.
  // RULE17: All-zero or all-one received word flags fail.
  // RULE18: Clock count must be 0 or 16, clock low at edges, else error.
  // RULE19: Pending frame error shows high on first output bit.
  // RULE20: Master keeps clock low around chip select edges.
  // RULE21: Frame overlapping reset output pulse sets frame error.
  // RULE22: Output high while reset output low; master drops such data.
  // RULE23: Low byte is 7-bit address plus access bit; high byte data.
  // RULE24: Writes take effect only after chip select rises.
  // RULE25: Frames in Restart mode are not interpreted.
  // RULE26: Valid frame word handed over as one core-clock strobe.
  // RULE27: Error clears after being shown in a clean legal frame.
*/
package sfc_pkg;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } sfc_mode_t;

  localparam int FRAME_BITS = 16;
  localparam int CNT_W_DEF  = 6;
  localparam int ADDR_W     = 7;
  localparam int ACC_BIT    = 7;
  localparam int STAT_BIT   = 6;
  localparam int DATA_LSB   = 8;
  localparam int ERR_POS    = 0;

  localparam logic [6:0] ADDR_MODE_CTRL  = 7'h01;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG    = 7'h02;
  localparam logic [6:0] ADDR_TIMER_CTRL = 7'h0c;
  localparam logic [6:0] ADDR_HW_CTRL    = 7'h0e;
  localparam logic [6:0] ADDR_GPIO_CTRL  = 7'h17;

  localparam int MREQ_LSB = 6;
  localparam logic [1:0] MREQ_NORMAL = 2'h0;
  localparam logic [1:0] MREQ_SLEEP  = 2'h1;
  localparam logic [1:0] MREQ_STOP   = 2'h2;
  localparam logic [1:0] MREQ_SRESET = 2'h3;

  localparam int MEAS_BIT = 2;
  localparam int TON_LSB  = 4;
  localparam int TPER_LSB = 0;
  localparam int TFLD_W   = 3;

  localparam logic       RST_FLAG = 1'b0;
  localparam logic [15:0] RST_WORD = 16'h0000;

endpackage : sfc_pkg

// [rtl/sfc_spi_slave_frame_check.sv]
/*
  SPI slave frame capture, frame supervision and command screening.
  Assumes the master keeps at least three core clocks between chip select
  edges and serial clock edges, and holds the serial clock still while
  chip select is high, so the link registers are static when read.
*/
module sfc_spi_slave_frame_check #(
  parameter int CNT_W = sfc_pkg::CNT_W_DEF
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_clk_en,
  input  wire logic              i_spi_sck,
  input  wire logic              i_spi_csn,
  input  wire logic              i_spi_sdi,
  output logic                   o_spi_sdo,
  output logic                   o_spi_sdo_oe,
  input  wire sfc_pkg::sfc_mode_t i_mode,
  input  wire logic              i_reset_out_n,
  input  wire logic [15:0]       i_resp_word,
  input  wire logic [7:0]        i_bus_wake_ctrl,
  input  wire logic [7:0]        i_wake_control_reg_a,
  input  wire logic [7:0]        i_wake_control_reg_b,
  input  wire logic [7:0]        i_gpio_ctrl,
  input  wire logic [7:0]        i_wake_status_reg_a,
  input  wire logic [7:0]        i_wake_status_reg_b,
  input  wire logic              i_timer_only_off,
  input  wire logic              i_voltage_measure_select,
  input  wire logic              i_fail_output_active,
  input  wire logic              i_cmd_fail_clear,
  output logic                   o_cmd_strobe,
  output logic [15:0]            o_cmd_word,
  output logic                   o_cmd_apply,
  output logic                   o_mode_strobe,
  output sfc_pkg::sfc_mode_t     o_mode_next,
  output logic                   o_soft_reset,
  output logic                   o_wd_trigger,
  output logic                   o_cmd_fail,
  output logic                   o_frame_err,
  output logic                   o_interrupt_out_n
);
  import sfc_pkg::*;

  generate
    if ((2 ** CNT_W) <= (2 * FRAME_BITS)) begin : g_chk
      $error("CNT_W too small for frame length");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LEN_FULL = CNT_W'(FRAME_BITS);

  function automatic logic [CNT_W-1:0] gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b = '0;
    for (int i = CNT_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == CNT_W - 1) ? 1'b0 : b[i + 1]);
    end
    return b;
  endfunction : gray2bin

  // Link side, serial clock domain
  logic [CNT_W-1:0] lk_fall_bin;
  logic [CNT_W-1:0] lk_fall_gray;
  logic [CNT_W-1:0] next_fall_bin;
  logic [15:0]      lk_shift;
  logic [CNT_W-1:0] lk_out_idx;
  logic             lk_out_clr;
  logic [15:0]      tx_shadow;
  logic             lk_out_bit;
  logic             spi_enabled;

  assign next_fall_bin = lk_fall_bin + 1'b1;

  // Free-running count never needs a frame reset; core takes differences
  always_ff @(negedge i_spi_sck or posedge i_rst) begin
    if (i_rst) begin
      lk_fall_bin  <= '0;
      lk_fall_gray <= '0;
    end else if (!i_spi_csn) begin
      lk_fall_bin  <= next_fall_bin; // see RULE18
      lk_fall_gray <= next_fall_bin ^ (next_fall_bin >> 1);
    end
  end

  // LSB first, no forwarding of shifted-out bits
  always_ff @(negedge i_spi_sck or posedge i_rst) begin
    if (i_rst) begin
      lk_shift <= RST_WORD;
    end else if (!i_spi_csn) begin
      lk_shift <= {i_spi_sdi, lk_shift[15:1]}; // see RULE4 see RULE2
    end
  end

  assign lk_out_clr = i_rst | i_spi_csn;

  // Index only matters inside a frame, so chip select may clear it
  always_ff @(posedge i_spi_sck or posedge lk_out_clr) begin
    if (lk_out_clr) begin
      lk_out_idx <= '0;
    end else if (lk_out_idx < LEN_FULL) begin
      lk_out_idx <= lk_out_idx + 1'b1; // see RULE4
    end
  end

  assign lk_out_bit = (lk_out_idx < LEN_FULL) ?
                      tx_shadow[lk_out_idx[3:0]] : 1'b0;

  assign spi_enabled = (i_mode == MODE_INIT) ||
                       (i_mode == MODE_NORMAL) ||
                       (i_mode == MODE_STOP); // see RULE1

  // Released as soon as chip select rises
  assign o_spi_sdo_oe = !i_spi_csn &&
                        (spi_enabled || !i_reset_out_n); // see RULE3
  assign o_spi_sdo    = !i_reset_out_n ? 1'b1 : lk_out_bit; // see RULE22

  // Core side
  logic [1:0]       csn_sync;
  logic             csn_q;
  logic [1:0]       sck_sync;
  logic [CNT_W-1:0] gray_s1;
  logic [CNT_W-1:0] gray_s2;
  logic             frame_start;
  logic             frame_end;
  logic [CNT_W-1:0] start_cnt;
  logic [CNT_W-1:0] frame_len;
  logic             sck_bad;
  logic             rst_seen;
  logic             err_shown;
  logic             err_pend;
  logic             len_ok;
  logic             frame_ok;
  logic             overlap;
  logic             deliver;
  logic             sleep_wake;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      csn_sync <= 2'h3;
      csn_q    <= 1'b1;
      sck_sync <= 2'h0;
      gray_s1  <= '0;
      gray_s2  <= '0;
    end else if (i_clk_en) begin
      csn_sync <= {csn_sync[0], i_spi_csn};
      csn_q    <= csn_sync[1];
      sck_sync <= {sck_sync[0], i_spi_sck};
      gray_s1  <= lk_fall_gray;
      gray_s2  <= gray_s1;
    end
  end

  assign frame_start = csn_q & ~csn_sync[1];
  assign frame_end   = ~csn_q & csn_sync[1];
  assign frame_len   = gray2bin(gray_s2) - start_cnt;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      start_cnt <= '0;
      sck_bad   <= 1'b0;
      rst_seen  <= 1'b0;
      err_shown <= 1'b0;
    end else if (i_clk_en) begin
      if (frame_start) begin
        start_cnt <= gray2bin(gray_s2);
        sck_bad   <= sck_sync[1]; // see RULE18 see RULE20
        rst_seen  <= !i_reset_out_n; // see RULE21
        err_shown <= err_pend;
      end else if (!csn_sync[1] && !i_reset_out_n) begin
        rst_seen  <= 1'b1; // see RULE21
      end
    end
  end

  assign len_ok   = (frame_len == '0) || (frame_len == LEN_FULL);
  assign frame_ok = len_ok && !sck_bad && !sck_sync[1]; // see RULE18
  assign overlap  = rst_seen || !i_reset_out_n; // see RULE21
  // Restart and other disabled modes drop the frame
  assign deliver  = frame_end && frame_ok && !overlap &&
                    (frame_len == LEN_FULL) &&
                    spi_enabled; // see RULE25 see RULE1

  // Set beats clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      err_pend <= RST_FLAG;
    end else if (i_clk_en && frame_end) begin
      if (!frame_ok || overlap) begin
        err_pend <= 1'b1; // see RULE18 see RULE21
      end else if (err_shown) begin
        err_pend <= 1'b0; // see RULE27
      end
    end
  end

  // Only refreshed between frames so the link sees a stable word
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_shadow <= RST_WORD;
    end else if (i_clk_en && csn_sync[1] && !frame_end) begin
      tx_shadow <= {i_resp_word[15:1], err_pend}; // see RULE19
    end
  end

  // Command screening
  logic [6:0]        c_addr;
  logic              c_wr;
  logic              c_stat;
  logic [7:0]        c_data;
  logic [1:0]        c_req;
  logic              no_wake_src;
  logic              wake_pend;
  logic              next_fail;
  logic              next_apply;
  logic              next_mgo;
  sfc_mode_t         next_mode;
  logic              next_soft;
  logic              next_wd;
  logic              next_int;
  logic              next_chain;
  logic [TFLD_W-1:0] t_on;
  logic [TFLD_W-1:0] t_per;

  assign c_addr = lk_shift[ADDR_W-1:0]; // see RULE23
  assign c_wr   = lk_shift[ACC_BIT];
  assign c_stat = lk_shift[STAT_BIT];
  assign c_data = lk_shift[DATA_LSB +: 8];
  assign c_req  = c_data[MREQ_LSB +: 2];
  assign t_on   = c_data[TON_LSB +: TFLD_W];
  assign t_per  = c_data[TPER_LSB +: TFLD_W];
  assign no_wake_src = ~|{i_bus_wake_ctrl, i_wake_control_reg_a,
                          i_wake_control_reg_b, i_gpio_ctrl};
  assign wake_pend   = |{i_wake_status_reg_a, i_wake_status_reg_b};

  always_comb begin
    next_fail  = 1'b0;
    next_apply = c_wr;
    next_mgo   = 1'b0;
    next_mode  = i_mode;
    next_soft  = 1'b0;
    next_wd    = 1'b0;
    next_int   = 1'b0;
    next_chain = 1'b0;
    if ((lk_shift == 16'h0000) || (lk_shift == 16'hffff)) begin
      next_fail  = 1'b1; // see RULE17
      next_apply = 1'b0;
    end else if (c_wr && !c_stat) begin
      if (c_addr == ADDR_MODE_CTRL) begin
        // Other mode-register bits are dropped when leaving Stop
        if (i_mode == MODE_STOP) begin
          next_apply = 1'b0; // see RULE12 see RULE9
        end
        case (c_req)
          MREQ_NORMAL: begin
            next_mgo  = 1'b1;
            next_mode = MODE_NORMAL;
          end
          MREQ_SRESET: begin
            next_soft = 1'b1;
          end
          MREQ_STOP: begin
            if (i_mode == MODE_INIT) begin
              next_fail  = 1'b1; // see RULE7
              next_apply = 1'b0;
              next_mgo   = 1'b1;
              next_mode  = MODE_NORMAL;
            end else if (i_mode != MODE_STOP) begin
              // Wake controls all zero is no failure here
              next_mgo  = 1'b1; // see RULE10
              next_mode = MODE_STOP;
              next_int  = wake_pend; // see RULE11
            end
          end
          default: begin
            if (i_mode == MODE_INIT) begin
              next_fail  = 1'b1; // see RULE7
              next_apply = 1'b0;
              next_mgo   = 1'b1;
              next_mode  = MODE_NORMAL;
            end else if (i_mode == MODE_STOP) begin
              next_fail  = 1'b1; // see RULE6
              next_mgo   = 1'b1;
              next_mode  = MODE_RESTART;
            end else if (no_wake_src) begin
              next_fail  = 1'b1; // see RULE13
              next_mgo   = 1'b1;
              next_mode  = MODE_RESTART;
            end else begin
              next_mgo   = 1'b1;
              next_mode  = MODE_SLEEP;
              next_chain = i_timer_only_off; // see RULE14
            end
          end
        endcase
      end else if (c_addr == ADDR_WATCHDOG_CONTROL_REG) begin
        if (^c_data) begin
          next_fail  = 1'b1; // see RULE8
          next_apply = 1'b0;
        end else begin
          next_wd = 1'b1;
        end
      end else if (i_mode == MODE_STOP) begin
        next_fail  = 1'b1; // see RULE9
        next_apply = 1'b0;
      end else if ((c_addr == ADDR_HW_CTRL) && c_data[MEAS_BIT] &&
                   (i_fail_output_active || (|i_gpio_ctrl))) begin
        next_fail  = 1'b1; // see RULE15
        next_apply = 1'b0;
      end else if ((c_addr == ADDR_GPIO_CTRL) &&
                   i_voltage_measure_select) begin
        next_fail  = 1'b1; // see RULE15
        next_apply = 1'b0;
      end else if ((c_addr == ADDR_TIMER_CTRL) && (t_on >= t_per)) begin
        next_fail  = 1'b1; // see RULE16
        next_apply = 1'b0;
      end
    end
  end

  // Everything leaves only after chip select has risen
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_strobe <= 1'b0;
      o_cmd_word   <= RST_WORD;
      o_cmd_apply  <= 1'b0;
      o_soft_reset <= 1'b0;
      o_wd_trigger <= 1'b0;
    end else if (i_clk_en) begin
      o_cmd_strobe <= deliver; // see RULE26 see RULE24
      o_cmd_apply  <= deliver && next_apply; // see RULE5
      o_soft_reset <= deliver && next_soft;
      o_wd_trigger <= deliver && next_wd; // see RULE8
      if (deliver) begin
        o_cmd_word <= lk_shift;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode_strobe <= 1'b0;
      o_mode_next   <= MODE_INIT;
      sleep_wake    <= 1'b0;
    end else if (i_clk_en) begin
      sleep_wake <= deliver && next_chain;
      if (deliver && next_mgo) begin
        o_mode_strobe <= 1'b1;
        o_mode_next   <= next_mode;
      end else if (sleep_wake) begin
        o_mode_strobe <= 1'b1; // see RULE14
        o_mode_next   <= MODE_RESTART;
      end else begin
        o_mode_strobe <= 1'b0;
      end
    end
  end

  // Sticky; a failure in the clearing cycle survives
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_fail        <= RST_FLAG;
      o_interrupt_out_n <= 1'b1;
    end else if (i_clk_en) begin
      if (deliver && next_fail) begin
        o_cmd_fail <= 1'b1; // see RULE5
      end else if (i_cmd_fail_clear) begin
        o_cmd_fail <= 1'b0;
      end
      o_interrupt_out_n <= !(deliver && next_int); // see RULE11
    end
  end

  assign o_frame_err = err_pend;

endmodule : sfc_spi_slave_frame_check

// [tb/sfc_props.sv]
/*
  Port assertions for the SPI slave frame checker.
  Bound to the design from the testbench file; core clock domain only.
*/
module sfc_props
  import sfc_pkg::*;
(
  input wire logic      i_core_clk,
  input wire logic      i_rst,
  input wire logic      i_spi_csn,
  input wire logic      i_reset_out_n,
  input wire sfc_mode_t i_mode,
  input wire logic      i_cmd_fail_clear,
  input wire logic      o_spi_sdo,
  input wire logic      o_spi_sdo_oe,
  input wire logic      o_cmd_strobe,
  input wire logic      o_cmd_apply,
  input wire logic      o_wd_trigger,
  input wire logic      o_cmd_fail,
  input wire logic      o_frame_err,
  input wire logic      o_interrupt_out_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_strobe_single:
    assert property (o_cmd_strobe |=> !o_cmd_strobe) else $error("long strobe");
  a_float_idle:
    assert property (i_spi_csn |-> !o_spi_sdo_oe) else $error("sdo driven");
  a_sdo_rst_high:
    assert property (!i_spi_csn && !i_reset_out_n |-> o_spi_sdo)
      else $error("sdo low in reset");
  a_mode_off:
    assert property (!i_spi_csn && i_reset_out_n && i_mode inside
      {MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE} |-> !o_spi_sdo_oe)
      else $error("port on in low mode");
  a_fail_sticky:
    assert property (o_cmd_fail && !i_cmd_fail_clear |=> o_cmd_fail)
      else $error("fail flag lost");
  a_apply_strobe:
    assert property (o_cmd_apply |-> o_cmd_strobe) else $error("stray apply");
  a_wd_strobe:
    assert property (o_wd_trigger |-> o_cmd_strobe) else $error("stray trigger");
  a_no_mid_strobe:
    assert property (!i_spi_csn [*6] |-> !o_cmd_strobe)
      else $error("strobe inside frame");
  a_int_pulse:
    assert property (!o_interrupt_out_n |-> o_cmd_strobe ##1 o_interrupt_out_n)
      else $error("bad interrupt pulse");
  a_err_drop:
    assert property ($rose(o_frame_err) |-> !o_cmd_strobe ##1 !o_cmd_strobe)
      else $error("errored frame decoded");
  a_err_clear:
    assert property ($fell(o_frame_err) |-> i_spi_csn)
      else $error("error cleared in frame");
endmodule : sfc_props

// [tb/sfc_spi_master_model.sv]
/*
  Behavioural SPI master, 30 ns serial clock idling low, LSB first.
  Data in moves on the rising clock, so it is steady at the falling one.
  The bench starts each frame through the frame task.
*/
module sfc_spi_master_model (
  output logic      o_sck,
  output logic      o_csn,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic sdo_line;

  // No pull on the line: a released output reads as garbage
  assign sdo_line = i_sdo_oe ? i_sdo : ~i_sdo;

  initial begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b1;
  end

  // Clock idles low; hi breaks that on purpose at the select edge
  task automatic frame(input logic [15:0] w, input int n, input bit hi,
                       output logic [15:0] rx, output logic oe);
    rx = 16'h0000;
    o_sck = hi;
    #5 o_csn = 1'b0;
    #40 o_sck = 1'b0;
    #40 rx[0] = sdo_line;
    oe = i_sdo_oe;
    for (int i = 0; i < n; i++) begin
      #15 rx[i] = sdo_line;
      o_sck = 1'b1;
      // Never in the falling-edge time step, where the design samples
      o_sdi = w[i];
      #15 o_sck = 1'b0;
    end
    #80 o_csn = 1'b1;
    // Released line shows no stale bit
    o_sdi = ~o_sdi;
    #80;
  endtask : frame
endmodule : sfc_spi_master_model

// [tb/testbench.sv]
/*
  Self-checking bench for the SPI slave frame checker.
  Core inputs move on the core clock; frames come from the master model.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sfc_pkg::*;

  logic        clk = 1'b0;
  logic        rst, sck, csn, sdi, sdo, oe, fclr, rso_n, tof, meas, fo;
  logic        stb, apl, wdt, cfail, ferr, int_n, oe_rx, apl_rx;
  logic        ce = 1'b1;
  logic        mstb, srst;
  logic [15:0] resp = 16'ha5c3;
  logic [15:0] rx, cword;
  logic [7:0]  bwk, wka, wkb, gpio, wsa, wsb;
  sfc_mode_t   mode, mnext;
  int          err_total = 0;
  int          n_compared = 0;
  int          n_str = 0;
  int          n_int = 0;
  int          n_wd = 0;
  int          n_ms = 0;
  int          n_srst = 0;
  int          s0, s1;

  sfc_spi_slave_frame_check sfc_spi_slave_frame_check_i (
    .i_core_clk(clk), .i_rst(rst), .i_clk_en(ce), .i_spi_sck(sck),
    .i_spi_csn(csn), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe),
    .i_mode(mode), .i_reset_out_n(rso_n), .i_resp_word(resp),
    .i_bus_wake_ctrl(bwk), .i_wake_control_reg_a(wka),
    .i_wake_control_reg_b(wkb), .i_gpio_ctrl(gpio),
    .i_wake_status_reg_a(wsa), .i_wake_status_reg_b(wsb),
    .i_timer_only_off(tof), .i_voltage_measure_select(meas),
    .i_fail_output_active(fo), .i_cmd_fail_clear(fclr),
    .o_cmd_strobe(stb), .o_cmd_word(cword), .o_cmd_apply(apl),
    .o_mode_strobe(mstb), .o_mode_next(mnext), .o_soft_reset(srst),
    .o_wd_trigger(wdt), .o_cmd_fail(cfail), .o_frame_err(ferr),
    .o_interrupt_out_n(int_n)
  );

  sfc_spi_master_model sfc_spi_master_model_i (
    .o_sck(sck), .o_csn(csn), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(oe)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (stb === 1'b1) begin
      n_str <= n_str + 1;
      apl_rx <= apl;
    end
    if (int_n === 1'b0) n_int <= n_int + 1;
    if (wdt === 1'b1) n_wd <= n_wd + 1;
    if (mstb === 1'b1) n_ms <= n_ms + 1;
    if (srst === 1'b1) n_srst <= n_srst + 1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Fixed wait covers strobe latency after select rises
  task automatic xfer(input logic [15:0] w, input int n, input bit hi);
    sfc_spi_master_model_i.frame(w, n, hi, rx, oe_rx);
    repeat (8) @(posedge clk);
  endtask : xfer

  task automatic cmd(input sfc_mode_t m, input logic [15:0] w,
                     input logic f, input sfc_mode_t nx);
    @(posedge clk);
    mode <= m;
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    @(posedge clk);
    chk(16'(cfail), 16'h0000);
    xfer(w, 16, 1'b0);
    chk(16'({cfail, mnext}), 16'({f, nx}));
  endtask : cmd

  initial begin
    {bwk, wka, wkb, gpio, wsa, wsb} = 48'h010101000000;
    {rst, fclr, rso_n, tof, meas, fo} = 6'h28;
    mode = MODE_NORMAL;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(16'({cfail, ferr, int_n}), 16'h0001);
    for (int k = 0; k < 6; k++) begin
      s0 = n_str;
      s1 = k < 3;
      @(posedge clk);
      mode <= sfc_mode_t'(k);
      xfer(16'h0041, 16, 1'b0);
      chk(16'({oe_rx, 1'(n_str - s0)}), 16'(s1 * 3));
      if (k < 3) chk(rx, {resp[15:1], 1'b0});
    end
    chk(cword, 16'h0041);
    $display("Test modes done");
    mode <= MODE_NORMAL;
    // Frozen core misses a whole frame
    ce <= 1'b0;
    s0 = n_str;
    xfer(16'h0041, 16, 1'b0);
    ce <= 1'b1;
    chk(16'(n_str - s0), 16'h0000);
    s0 = n_str;
    xfer(16'h0041, 15, 1'b0);
    chk(16'({ferr, 1'(n_str - s0)}), 16'h0002);
    xfer(16'h0000, 0, 1'b0);
    chk(16'({rx[0], ferr}), 16'h0002);
    xfer(16'h0041, 16, 1'b1);
    chk(16'(ferr), 16'h0001);
    xfer(16'h0041, 16, 1'b0);
    chk(rx, {resp[15:1], 1'b1});
    chk(16'(ferr), 16'h0000);
    rso_n <= 1'b0;
    xfer(16'h138c, 16, 1'b0);
    chk(rx, 16'hffff);
    rso_n <= 1'b1;
    xfer(16'h0000, 0, 1'b0);
    chk(16'({rx[0], ferr}), 16'h0002);
    $display("Test frame errors done");
    cmd(MODE_NORMAL, 16'h138c, 1'b0, MODE_INIT);
    chk(16'(apl_rx), 16'h0001);
    cmd(MODE_NORMAL, 16'h228c, 1'b1, MODE_INIT);
    s0 = n_wd;
    cmd(MODE_NORMAL, 16'h0382, 1'b0, MODE_INIT);
    cmd(MODE_NORMAL, 16'h0182, 1'b1, MODE_INIT);
    chk(16'(n_wd - s0), 16'h0001);
    cmd(MODE_NORMAL, 16'h0000, 1'b1, MODE_INIT);
    cmd(MODE_NORMAL, 16'hffff, 1'b1, MODE_INIT);
    fo <= 1'b1;
    cmd(MODE_NORMAL, 16'h048e, 1'b1, MODE_INIT);
    {fo, meas} <= 2'h1;
    cmd(MODE_NORMAL, 16'h0197, 1'b1, MODE_INIT);
    meas <= 1'b0;
    cmd(MODE_INIT, 16'h8081, 1'b1, MODE_NORMAL);
    cmd(MODE_STOP, 16'h4081, 1'b1, MODE_RESTART);
    cmd(MODE_STOP, 16'h138c, 1'b1, MODE_RESTART);
    cmd(MODE_STOP, 16'h00c1, 1'b0, MODE_RESTART);
    cmd(MODE_STOP, 16'h0081, 1'b0, MODE_NORMAL);
    chk(16'(apl_rx), 16'h0000);
    cmd(MODE_STOP, 16'h0382, 1'b0, MODE_NORMAL);
    s0 = n_srst;
    cmd(MODE_STOP, 16'hc081, 1'b0, MODE_NORMAL);
    chk(16'(n_srst - s0), 16'h0001);
    {bwk, wkb} <= 16'h0000;
    cmd(MODE_NORMAL, 16'h8081, 1'b0, MODE_STOP);
    wsa <= 8'h01;
    s0 = n_int;
    cmd(MODE_NORMAL, 16'h8081, 1'b0, MODE_STOP);
    chk(16'(n_int - s0), 16'h0001);
    {wsa, wka} <= 16'h0000;
    cmd(MODE_NORMAL, 16'h4081, 1'b1, MODE_RESTART);
    chk(16'(apl_rx), 16'h0001);
    {wka, tof} <= 9'h003;
    s0 = n_ms;
    cmd(MODE_NORMAL, 16'h4081, 1'b0, MODE_RESTART);
    chk(16'(n_ms - s0), 16'h0002);
    $display("Test commands done");
    final_report();
  end

  // Whole sequence needs well under a tenth of this
  initial begin
    #400000;
    err_total++;
    final_report();
  end
endmodule : testbench

bind sfc_spi_slave_frame_check sfc_props sfc_props_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_spi_csn(i_spi_csn),
  .i_reset_out_n(i_reset_out_n), .i_mode(i_mode),
  .i_cmd_fail_clear(i_cmd_fail_clear), .o_spi_sdo(o_spi_sdo),
  .o_spi_sdo_oe(o_spi_sdo_oe), .o_cmd_strobe(o_cmd_strobe),
  .o_cmd_apply(o_cmd_apply), .o_wd_trigger(o_wd_trigger),
  .o_cmd_fail(o_cmd_fail), .o_frame_err(o_frame_err),
  .o_interrupt_out_n(o_interrupt_out_n)
);
